/* File: rtl/swc_defs.svh */
`ifndef SWC_DEFS_SVH
`define SWC_DEFS_SVH

// clock and reset timer figures
`define SWC_CLK_PERIOD_NS   8
`define SWC_DRT_POR_US      18000
`define SWC_DRT_SUB_US      300
`define SWC_DRT_POR_CYC     ((`SWC_DRT_POR_US * 1000) / `SWC_CLK_PERIOD_NS)
`define SWC_DRT_SUB_CYC     ((`SWC_DRT_SUB_US * 1000) / `SWC_CLK_PERIOD_NS)
// watchdog oscillator ticks per time-out, before prescaler
`define SWC_WDT_TICKS       18

// register byte offsets
`define SWC_OFS_STATUS      8'h00
`define SWC_OFS_CTRL        8'h04
`define SWC_OFS_INT_STAT    8'h08
`define SWC_OFS_INT_MASK    8'h0C

// status register fields
`define SWC_ST_PD_BIT       3
`define SWC_ST_TO_BIT       4
`define SWC_ST_PCWF_BIT     7

// control register fields and reset values
`define SWC_CT_WOC_BIT      0
`define SWC_CT_PSA_BIT      1
`define SWC_CT_PS_LSB       2
`define SWC_CT_WOC_RST      1'h1
`define SWC_CT_PSA_RST      1'h1
`define SWC_CT_PS_RST       3'h7

// interrupt status bits
`define SWC_IRQ_SLEEP       0
`define SWC_IRQ_MASTER_CLEAR_PIN_WAKE   1
`define SWC_IRQ_WDT         2
`define SWC_IRQ_PIN_WAKE    3
`define SWC_IRQ_W           4

// port inputs watched for wake-on-change
`define SWC_WAKE_PIN0       0
`define SWC_WAKE_PIN1       1
`define SWC_WAKE_PIN2       3

`endif

/* File: rtl/swc_pkg.sv */
package swc_pkg;

    typedef enum logic [2:0] {
        ST_DRT   = 3'h1,
        ST_RUN   = 3'h2,
        ST_SLEEP = 3'h4
    } swc_state_t;

endpackage : swc_pkg

/* File: rtl/swc_top.sv */
// What this block does
// - sleep entered only by sleep instruction
// - sleep entry clears watchdog and prescaler
// - sleep entry sets time-out, clears power-down
// - sleep entry stops main oscillator driver
// - port drive states frozen during sleep
// - watchdog reset never drives master-clear pin
// - master-clear wakes sleep when pin enabled
// - watchdog time-out wakes only when enabled
// - change on inputs 0,1,3 wakes
// - every wake is a full reset
// - watchdog wake clears time-out flag
// - power-down flag set at power-up
// - pin-change flag against last port reference
// - wake clears watchdog regardless of source
// - flags kept; master-clear pulse while running leaves them
// - watchdog time-out restarts reset timer
`timescale 1ns/1ns
`include "swc_defs.svh"
module swc_top #(
    parameter int unsigned PORT_W    = 6,
    parameter int unsigned DRT_W     = 22,
    parameter int unsigned DRT_POR   = `SWC_DRT_POR_CYC,
    parameter int unsigned DRT_SUB   = `SWC_DRT_SUB_CYC,
    parameter int unsigned WDT_TICKS = `SWC_WDT_TICKS
) (
    input  wire logic                core_clk_in,
    input  wire logic                sys_rst_in,
    input  wire logic                ce_in,
    input  wire logic                psel_in,
    input  wire logic                penable_in,
    input  wire logic                pwrite_in,
    input  wire logic [7:0]          paddr_in,
    input  wire logic [31:0]         pwdata_in,
    output logic [31:0]              prdata_out,
    output logic                     pready_out,
    output logic                     pslverr_out,
    output logic                     irq_out,
    input  wire logic                sleep_exec_in,
    input  wire logic                clrwdt_exec_in,
    input  wire logic                port_access_in,
    input  wire logic                watchdog_config_enable_in,
    input  wire logic                master_clear_pin_enable_in,
    input  wire logic                master_clear_pin_n_in,
    input  wire logic                wdt_osc_tick_in,
    input  wire logic [PORT_W-1:0]   port_in,
    input  wire logic [PORT_W-1:0]   port_drv_in,
    input  wire logic [PORT_W-1:0]   port_oe_in,
    output logic [PORT_W-1:0]        port_drv_out,
    output logic [PORT_W-1:0]        port_oe_out,
    output logic                     core_reset_out,
    output logic                     osc_enable_out,
    output swc_pkg::swc_state_t      power_state_out,
    output logic                     time_out_flag_n_out,
    output logic                     power_down_flag_n_out,
    output logic                     pin_change_wake_flag_out
);
    import swc_pkg::*;

    localparam int unsigned WAKE_N = 3;
    localparam int unsigned WAKE_IDX [WAKE_N] = '{
        `SWC_WAKE_PIN0, `SWC_WAKE_PIN1, `SWC_WAKE_PIN2};

    typedef struct packed {
        swc_state_t          st;
        logic [DRT_W-1:0]    device_reset_timer;
        logic                time_out_flag_n;
        logic                power_down_flag_n;
        logic                pin_change_wake_flag;
        logic                wake_on_change_enable_n;
        logic                psa;
        logic [2:0]          ps;
        logic [WAKE_N-1:0]   ref_lvl;
        logic [PORT_W-1:0]   drv;
        logic [PORT_W-1:0]   oe;
        logic [`SWC_IRQ_W-1:0] istat;
        logic [`SWC_IRQ_W-1:0] imask;
        logic                irq;
        logic                core_rst;
        logic                osc_en;
        logic                wdt_clr;
        logic [31:0]         rdata;
        logic                rdy;
        logic                err;
    } swc_top_st_t;

    localparam swc_top_st_t RST = '{
        st:                      ST_DRT,
        device_reset_timer:                     DRT_W'(DRT_POR - 1),
        time_out_flag_n:         1'h1,
        power_down_flag_n:       1'h1,
        wake_on_change_enable_n: `SWC_CT_WOC_RST,
        psa:                     `SWC_CT_PSA_RST,
        ps:                      `SWC_CT_PS_RST,
        core_rst:                1'h1,
        osc_en:                  1'h1,
        wdt_clr:                 1'h1,
        default:                 '0
    };

    swc_top_st_t         r;
    swc_top_st_t         n;
    swc_wdt_if           wif ();
    logic [WAKE_N-1:0]   wake_lvl;
    logic                master_clear_pin_low;
    logic                wd_to;
    logic                pin_wake;
    logic                wake_any;
    logic                sleep_go;
    logic                access;
    logic                hit;
    logic [31:0]         rd_mux;
    logic [`SWC_IRQ_W-1:0] ev;
    logic [`SWC_IRQ_W-1:0] rd_clr;

    // wake pins are compared every cycle; the core is the only part
    // that stops, this block keeps its clock while asleep
    for (genvar g = 0; g < WAKE_N; g++) begin : g_wake
        assign wake_lvl[g] = port_in[WAKE_IDX[g]];
    end

    assign master_clear_pin_low = master_clear_pin_enable_in && !master_clear_pin_n_in;
    assign wd_to    = wif.timeout;
    assign pin_wake = !r.wake_on_change_enable_n &&
                      |(wake_lvl ^ r.ref_lvl);
    assign wake_any = master_clear_pin_low || wd_to || pin_wake;
    assign sleep_go = r.st == ST_RUN && sleep_exec_in &&
                      !master_clear_pin_low && !wd_to;

    assign wif.clr  = r.wdt_clr;
    assign wif.en   = watchdog_config_enable_in;
    assign wif.psa  = r.psa;
    assign wif.ps   = r.ps;
    assign wif.tick = wdt_osc_tick_in;

    swc_wdt #(
        .TICKS (WDT_TICKS)
    ) u_wdt (
        .core_clk_in (core_clk_in),
        .sys_rst_in  (sys_rst_in),
        .ce_in       (ce_in),
        .wif         (wif)
    );

    assign access = psel_in && penable_in;

    always_comb begin
        hit    = 1'b1;
        rd_mux = 32'h0000_0000;
        case (paddr_in)
            `SWC_OFS_STATUS: begin
                rd_mux[`SWC_ST_PCWF_BIT] = r.pin_change_wake_flag;
                rd_mux[`SWC_ST_TO_BIT]   = r.time_out_flag_n;
                rd_mux[`SWC_ST_PD_BIT]   = r.power_down_flag_n;
            end
            `SWC_OFS_CTRL: begin
                rd_mux[`SWC_CT_WOC_BIT] = r.wake_on_change_enable_n;
                rd_mux[`SWC_CT_PSA_BIT] = r.psa;
                rd_mux[`SWC_CT_PS_LSB +: 3] = r.ps;
            end
            `SWC_OFS_INT_STAT: rd_mux[`SWC_IRQ_W-1:0] = r.istat;
            `SWC_OFS_INT_MASK: rd_mux[`SWC_IRQ_W-1:0] = r.imask;
            default: hit = 1'b0;
        endcase
    end

    always_comb begin
        n         = r;
        n.wdt_clr = 1'b0;
        ev        = '0;
        rd_clr    = '0;

        // outputs follow the core until sleep, then stay as they were
        if (r.st != ST_SLEEP) begin
            n.drv = port_drv_in;
            n.oe  = port_oe_in;
        end
        if (r.st == ST_RUN && port_access_in) begin
            n.ref_lvl = wake_lvl;
        end
        // a master-clear in the same cycle keeps the flags as they are
        if (r.st == ST_RUN && clrwdt_exec_in && !master_clear_pin_low) begin
            n.wdt_clr           = 1'b1;
            n.time_out_flag_n   = 1'b1;
            n.power_down_flag_n = 1'b1;
        end

        case (r.st)
            ST_DRT: begin
                n.wdt_clr = 1'b1;
                // timer only runs once master-clear is released
                if (!master_clear_pin_low) begin
                    if (r.device_reset_timer == '0) begin
                        n.st       = ST_RUN;
                        n.core_rst = 1'b0;
                    end else begin
                        n.device_reset_timer = r.device_reset_timer - DRT_W'(1);
                    end
                end
            end
            ST_RUN: begin
                if (master_clear_pin_low) begin
                    // flags untouched by a master-clear pulse
                    n.st       = ST_DRT;
                    n.core_rst = 1'b1;
                    n.device_reset_timer      = DRT_W'(DRT_SUB - 1);
                end else if (wd_to) begin
                    // internal only: the master-clear pin is input only
                    n.st                   = ST_DRT;
                    n.core_rst             = 1'b1;
                    n.device_reset_timer                  = DRT_W'(DRT_SUB - 1);
                    n.time_out_flag_n      = 1'b0;
                    n.pin_change_wake_flag = 1'b0;
                    ev[`SWC_IRQ_WDT]       = 1'b1;
                end else if (sleep_exec_in) begin
                    n.st                = ST_SLEEP;
                    n.osc_en            = 1'b0;
                    n.wdt_clr           = 1'b1;
                    n.time_out_flag_n   = 1'b1;
                    n.power_down_flag_n = 1'b0;
                    ev[`SWC_IRQ_SLEEP]  = 1'b1;
                end
            end
            ST_SLEEP: begin
                // same-cycle causes: master-clear, then watchdog, then pin
                if (master_clear_pin_low) begin
                    n.time_out_flag_n        = 1'b1;
                    n.pin_change_wake_flag   = 1'b0;
                    ev[`SWC_IRQ_MASTER_CLEAR_PIN_WAKE]   = 1'b1;
                end else if (wd_to) begin
                    n.time_out_flag_n        = 1'b0;
                    n.pin_change_wake_flag   = 1'b0;
                    ev[`SWC_IRQ_WDT]         = 1'b1;
                end else if (pin_wake) begin
                    n.time_out_flag_n        = 1'b1;
                    n.pin_change_wake_flag   = 1'b1;
                    ev[`SWC_IRQ_PIN_WAKE]    = 1'b1;
                end
                if (wake_any) begin
                    n.st       = ST_DRT;
                    n.core_rst = 1'b1;
                    n.osc_en   = 1'b1;
                    n.wdt_clr  = 1'b1;
                    n.device_reset_timer      = DRT_W'(DRT_SUB - 1);
                end
            end
            default: begin
                n.st       = ST_DRT;
                n.core_rst = 1'b1;
                n.osc_en   = 1'b1;
                n.device_reset_timer      = DRT_W'(DRT_SUB - 1);
            end
        endcase

        // one wait state: data and error are registered on the same edge that raises pready
        n.rdy = access && !r.rdy;
        n.err = 1'b0;
        if (access && !r.rdy) begin
            n.rdata = rd_mux;
            n.err   = !hit;
        end
        if (access && r.rdy && pwrite_in) begin
            if (paddr_in == `SWC_OFS_CTRL) begin
                n.wake_on_change_enable_n = pwdata_in[`SWC_CT_WOC_BIT];
                n.psa = pwdata_in[`SWC_CT_PSA_BIT];
                n.ps  = pwdata_in[`SWC_CT_PS_LSB +: 3];
            end
            if (paddr_in == `SWC_OFS_INT_MASK) begin
                n.imask = pwdata_in[`SWC_IRQ_W-1:0];
            end
        end
        // only bits that were reported are cleared; a new event wins
        if (access && r.rdy && !pwrite_in &&
            paddr_in == `SWC_OFS_INT_STAT) begin
            rd_clr = r.rdata[`SWC_IRQ_W-1:0];
        end
        n.istat = (r.istat & ~rd_clr) | ev;
        n.irq   = |(n.istat & n.imask);
    end

    always_ff @(posedge core_clk_in) begin
        if (sys_rst_in) begin
            r <= RST;
        end else if (ce_in) begin
            r <= n;
        end
    end

    assign prdata_out               = r.rdata;
    assign pready_out               = r.rdy;
    assign pslverr_out              = r.err;
    assign irq_out                  = r.irq;
    assign port_drv_out             = r.drv;
    assign port_oe_out              = r.oe;
    assign core_reset_out           = r.core_rst;
    assign osc_enable_out           = r.osc_en;
    assign power_state_out          = r.st;
    assign time_out_flag_n_out      = r.time_out_flag_n;
    assign power_down_flag_n_out    = r.power_down_flag_n;
    assign pin_change_wake_flag_out = r.pin_change_wake_flag;

    default clocking cb @(posedge core_clk_in);
    endclocking
    default disable iff (sys_rst_in);

    sequence s_sleep_go;
        ce_in && sleep_go;
    endsequence

    sequence s_wake;
        ce_in && r.st == ST_SLEEP && wake_any;
    endsequence

    a_sleep_only_instr: assert property (
        $rose(r.st == ST_SLEEP) |-> $past(sleep_go))
        else $error("sleep entered without sleep instruction");

    a_sleep_wdt_clear: assert property (
        s_sleep_go |=> wif.clr ##1 !wd_to)
        else $error("watchdog not cleared on sleep entry");

    a_sleep_flags: assert property (
        s_sleep_go |=> time_out_flag_n_out && !power_down_flag_n_out)
        else $error("flags wrong after sleep entry");

    a_osc_stopped: assert property (
        power_state_out == ST_SLEEP |-> !osc_enable_out && !core_reset_out)
        else $error("oscillator running while asleep");

    a_ports_frozen: assert property (
        (power_state_out == ST_SLEEP) [*2] |->
            $stable(port_drv_out) && $stable(port_oe_out))
        else $error("port drive changed while asleep");

    a_master_clear_pin_wake: assert property (
        s_wake ##0 master_clear_pin_low |=> power_state_out == ST_DRT &&
            time_out_flag_n_out && !power_down_flag_n_out &&
            !pin_change_wake_flag_out)
        else $error("master-clear wake flags wrong");

    a_wdt_wake: assert property (
        s_wake ##0 (!master_clear_pin_low && wd_to) |=> !time_out_flag_n_out &&
            !power_down_flag_n_out && !pin_change_wake_flag_out)
        else $error("watchdog wake flags wrong");

    a_wdt_needs_en: assert property (
        !watchdog_config_enable_in [*2] |-> !wd_to)
        else $error("watchdog fired while disabled");

    a_pin_wake: assert property (
        s_wake ##0 (!master_clear_pin_low && !wd_to) |=> pin_change_wake_flag_out &&
            time_out_flag_n_out && !power_down_flag_n_out)
        else $error("pin-change wake flags wrong");

    a_wake_is_reset: assert property (
        s_wake |=> core_reset_out && osc_enable_out ##1 wif.clr == 1'b1)
        else $error("wake did not give full reset");

    a_wdt_drt_restart: assert property (
        ce_in && r.st == ST_RUN && wd_to && !master_clear_pin_low |=>
            core_reset_out && r.device_reset_timer == DRT_W'(DRT_SUB - 1))
        else $error("watchdog did not restart reset timer");

    a_pd_power_up: assert property (
        $past(sys_rst_in) |-> power_down_flag_n_out &&
            time_out_flag_n_out)
        else $error("power-down flag not set after power-up");

    a_pd_clear_cause: assert property (
        $fell(power_down_flag_n_out) |-> $past(sleep_go))
        else $error("power-down flag cleared without sleep");

    a_master_clear_pin_keeps_flags: assert property (
        ce_in && r.st == ST_RUN && master_clear_pin_low |=>
            $stable(time_out_flag_n_out) &&
            $stable(power_down_flag_n_out) &&
            $stable(pin_change_wake_flag_out))
        else $error("master-clear pulse changed flags");

    a_irq_level: assert property (
        irq_out == |(r.istat & r.imask))
        else $error("interrupt level does not match status");
endmodule : swc_top

/* File: rtl/swc_wdt.sv */
`timescale 1ns/1ns
`include "swc_defs.svh"
module swc_wdt #(
    parameter int unsigned TICKS = `SWC_WDT_TICKS,
    parameter int unsigned CNT_W = 16
) (
    input  wire logic core_clk_in,
    input  wire logic sys_rst_in,
    input  wire logic ce_in,
    swc_wdt_if.wdt    wif
);
    import swc_pkg::*;

    typedef struct packed {
        logic [6:0]       pre;
        logic [CNT_W-1:0] cnt;
        logic             to;
    } swc_wdt_st_t;

    swc_wdt_st_t r;
    swc_wdt_st_t n;
    logic [6:0]  lim;

    // prescaler ratio 1:2^ps, so ps of 7 gives 1:128
    assign lim = 7'((8'h01 << wif.ps) - 8'h01);

    always_comb begin
        n    = r;
        n.to = 1'b0;
        if (!wif.en || wif.clr) begin
            n.pre = '0;
            n.cnt = '0;
        end else if (wif.tick) begin
            if (wif.psa && r.pre != lim) begin
                n.pre = r.pre + 7'h01;
            end else begin
                n.pre = '0;
                if (r.cnt == CNT_W'(TICKS - 1)) begin
                    n.cnt = '0;
                    n.to  = 1'b1;
                end else begin
                    n.cnt = r.cnt + CNT_W'(1);
                end
            end
        end
    end

    always_ff @(posedge core_clk_in) begin
        if (sys_rst_in) begin
            r <= '0;
        end else if (ce_in) begin
            r <= n;
        end
    end

    assign wif.timeout = r.to;

    a_wdt_clear_hold: assert property (@(posedge core_clk_in)
        disable iff (sys_rst_in)
        ce_in && wif.clr |=> r.cnt == '0 && r.pre == '0 && !r.to)
        else $error("watchdog not cleared by clear request");
endmodule : swc_wdt

/* File: rtl/swc_wdt_if.sv */
`timescale 1ns/1ns
interface swc_wdt_if;
    logic       clr;
    logic       en;
    logic       psa;
    logic [2:0] ps;
    logic       tick;
    logic       timeout;

    modport ctl (output clr, en, psa, ps, tick, input timeout);
    modport wdt (input clr, en, psa, ps, tick, output timeout);
endinterface : swc_wdt_if

/* File: tb/tb.sv */
`timescale 1ns/1ns
module tb;
    import swc_pkg::*;
    localparam int unsigned DRT_POR = 20;
    localparam int unsigned DRT_SUB = 5;
    localparam int unsigned TICKS   = 4;

    logic        core_clk_in    = 1'b0;
    logic        sys_rst_in     = 1'b1;
    logic        psel_in        = 1'b0;
    logic        penable_in     = 1'b0;
    logic        pwrite_in      = 1'b0;
    logic [7:0]  paddr_in       = 8'h00;
    logic [31:0] pwdata_in      = 32'h0000_0000;
    logic        sleep_exec_in  = 1'b0;
    logic        port_access_in = 1'b0;
    logic        clrwdt         = 1'b0;
    logic        wdt_en         = 1'b1;
    logic        master_clear_pin_en        = 1'b1;
    logic        master_clear_pin_n         = 1'b1;
    logic        wdt_tick       = 1'b0;
    logic [5:0]  port_in        = 6'h00;
    logic [5:0]  port_drv_in    = 6'h00;
    logic [5:0]  port_oe_in     = 6'h00;
    logic [31:0] prdata_out;
    logic        pready_out;
    logic        pslverr_out;
    logic        irq_out;
    logic [5:0]  port_drv_out;
    logic [5:0]  port_oe_out;
    logic        core_reset_out;
    logic        osc_enable_out;
    swc_state_t  power_state_out;
    logic        to_n;
    logic        pd_n;
    logic        pcw;
    int          fail_count     = 0;
    int          cmp_count      = 0;
    int          cyc            = 0;

    swc_top #(
        .DRT_POR   (DRT_POR),
        .DRT_SUB   (DRT_SUB),
        .WDT_TICKS (TICKS)
    ) i_swc_top (
        .core_clk_in              (core_clk_in),
        .sys_rst_in               (sys_rst_in),
        .ce_in                    (1'b1),
        .psel_in                  (psel_in),
        .penable_in               (penable_in),
        .pwrite_in                (pwrite_in),
        .paddr_in                 (paddr_in),
        .pwdata_in                (pwdata_in),
        .prdata_out               (prdata_out),
        .pready_out               (pready_out),
        .pslverr_out              (pslverr_out),
        .irq_out                  (irq_out),
        .sleep_exec_in            (sleep_exec_in),
        .clrwdt_exec_in           (clrwdt),
        .port_access_in           (port_access_in),
        .watchdog_config_enable_in(wdt_en),
        .master_clear_pin_enable_in           (master_clear_pin_en),
        .master_clear_pin_n_in    (master_clear_pin_n),
        .wdt_osc_tick_in          (wdt_tick),
        .port_in                  (port_in),
        .port_drv_in              (port_drv_in),
        .port_oe_in               (port_oe_in),
        .port_drv_out             (port_drv_out),
        .port_oe_out              (port_oe_out),
        .core_reset_out           (core_reset_out),
        .osc_enable_out           (osc_enable_out),
        .power_state_out          (power_state_out),
        .time_out_flag_n_out      (to_n),
        .power_down_flag_n_out    (pd_n),
        .pin_change_wake_flag_out (pcw)
    );

    always #4 core_clk_in = ~core_clk_in;

    task automatic results;
        $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : results

    // run is about two hundred cycles; a hang is cut off well past that
    always @(posedge core_clk_in) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            fail_count++;
            results();
        end
    end

    task automatic chk(input string name, input logic [31:0] seen,
                       input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            fail_count++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk

    task automatic apb(input logic wr, input logic [7:0] addr,
                       input logic [31:0] wd, output logic [31:0] rd,
                       output logic err);
        int n;
        n = 0;
        @(posedge core_clk_in);
        psel_in <= 1'b1;
        penable_in <= 1'b0;
        pwrite_in <= wr;
        paddr_in <= addr;
        pwdata_in <= wd;
        @(posedge core_clk_in);
        penable_in <= 1'b1;
        // pready is taken on the same edge at which the slave sees it
        do begin
            @(posedge core_clk_in);
            n++;
        end while (pready_out !== 1'b1 && n < 20);
        if (pready_out !== 1'b1) begin
            fail_count++;
        end
        rd = prdata_out;
        err = pslverr_out;
        psel_in <= 1'b0;
        penable_in <= 1'b0;
    endtask : apb

    task automatic rd_chk(input logic [7:0] addr, input logic [31:0] exp,
                          input logic exp_err);
        logic [31:0] rd;
        logic        err;
        apb(1'b0, addr, 32'h0000_0000, rd, err);
        chk("read data", rd, exp);
        chk("read error", {31'h0, err}, {31'h0, exp_err});
    endtask : rd_chk

    task automatic wr(input logic [7:0] addr, input logic [31:0] wd);
        logic [31:0] rd;
        logic        err;
        apb(1'b1, addr, wd, rd, err);
    endtask : wr

    task automatic wait_st(input swc_state_t s, input int max);
        int n;
        n = 0;
        @(negedge core_clk_in);
        while (power_state_out !== s && n < max) begin
            n++;
            @(negedge core_clk_in);
        end
        chk("power state", {29'h0, power_state_out}, {29'h0, s});
    endtask : wait_st

    task automatic flags(input logic [2:0] exp);
        chk("to pd pcw flags", {29'h0, to_n, pd_n, pcw}, {29'h0, exp});
    endtask : flags

    task automatic do_sleep;
        @(posedge core_clk_in);
        sleep_exec_in <= 1'b1;
        @(posedge core_clk_in);
        sleep_exec_in <= 1'b0;
        repeat (2) @(negedge core_clk_in);
    endtask : do_sleep

    task automatic latch_ref;
        @(posedge core_clk_in);
        port_access_in <= 1'b1;
        @(posedge core_clk_in);
        port_access_in <= 1'b0;
    endtask : latch_ref

    initial begin
        repeat (12) @(posedge core_clk_in);
        sys_rst_in <= 1'b0;
        @(negedge core_clk_in);
        flags(3'b110);
        chk("core reset", {31'h0, core_reset_out}, 32'h0000_0001);
        do_sleep();
        wait_st(ST_DRT, 0);
        wait_st(ST_RUN, DRT_POR + 5);
        chk("core reset", {31'h0, core_reset_out}, 32'h0000_0000);
        rd_chk(8'h00, 32'h0000_0018, 1'b0);
        rd_chk(8'h04, 32'h0000_001F, 1'b0);
        rd_chk(8'h10, 32'h0000_0000, 1'b1);
        wr(8'h0C, 32'h0000_000F);
        wr(8'h04, 32'h0000_001C);
        port_drv_in <= 6'h2A;
        port_oe_in <= 6'h0F;
        latch_ref();
        do_sleep();
        wait_st(ST_SLEEP, 0);
        chk("osc enable", {31'h0, osc_enable_out}, 32'h0000_0000);
        flags(3'b100);
        chk("irq", {31'h0, irq_out}, 32'h0000_0001);
        port_drv_in <= 6'h15;
        port_oe_in <= 6'h30;
        repeat (3) @(negedge core_clk_in);
        chk("port drive", {26'h0, port_drv_out}, 32'h0000_002A);
        chk("port enable", {26'h0, port_oe_out}, 32'h0000_000F);
        @(posedge core_clk_in);
        port_in <= 6'h01;
        wait_st(ST_DRT, 4);
        flags(3'b101);
        chk("osc enable", {31'h0, osc_enable_out}, 32'h0000_0001);
        chk("core reset", {31'h0, core_reset_out}, 32'h0000_0001);
        rd_chk(8'h08, 32'h0000_0009, 1'b0);
        rd_chk(8'h08, 32'h0000_0000, 1'b0);
        chk("irq", {31'h0, irq_out}, 32'h0000_0000);
        wait_st(ST_RUN, DRT_SUB + 5);
        latch_ref();
        wr(8'h0C, 32'h0000_0000);
        do_sleep();
        @(posedge core_clk_in);
        master_clear_pin_n <= 1'b0;
        wait_st(ST_DRT, 4);
        repeat (10) @(negedge core_clk_in);
        wait_st(ST_DRT, 0);
        flags(3'b100);
        chk("irq masked", {31'h0, irq_out}, 32'h0000_0000);
        rd_chk(8'h08, 32'h0000_0003, 1'b0);
        @(posedge core_clk_in);
        master_clear_pin_n <= 1'b1;
        wait_st(ST_RUN, DRT_SUB + 5);
        wr(8'h0C, 32'h0000_000F);
        // wake-on-change off, prescaler away from the watchdog
        wr(8'h04, 32'h0000_0001);
        do_sleep();
        @(posedge core_clk_in);
        port_in <= 6'h08;
        repeat (4) @(negedge core_clk_in);
        wait_st(ST_SLEEP, 0);
        repeat (TICKS) begin
            @(posedge core_clk_in);
            wdt_tick <= 1'b1;
            @(posedge core_clk_in);
            wdt_tick <= 1'b0;
        end
        wait_st(ST_DRT, 4);
        flags(3'b000);
        rd_chk(8'h08, 32'h0000_0005, 1'b0);
        wait_st(ST_RUN, DRT_SUB + 5);
        @(posedge core_clk_in);
        master_clear_pin_n <= 1'b0;
        wait_st(ST_DRT, 4);
        flags(3'b000);
        @(posedge core_clk_in);
        master_clear_pin_n <= 1'b1;
        wait_st(ST_RUN, DRT_SUB + 5);
        flags(3'b000);
        // watchdog and master-clear both disabled: nothing may wake
        @(posedge core_clk_in);
        wdt_en <= 1'b0;
        master_clear_pin_en <= 1'b0;
        do_sleep();
        @(posedge core_clk_in);
        master_clear_pin_n <= 1'b0;
        repeat (TICKS) begin
            @(posedge core_clk_in);
            wdt_tick <= 1'b1;
            @(posedge core_clk_in);
            wdt_tick <= 1'b0;
        end
        repeat (4) @(negedge core_clk_in);
        wait_st(ST_SLEEP, 0);
        @(posedge core_clk_in);
        master_clear_pin_en <= 1'b1;
        wait_st(ST_DRT, 4);
        flags(3'b100);
        @(posedge core_clk_in);
        master_clear_pin_n <= 1'b1;
        wait_st(ST_RUN, DRT_SUB + 5);
        @(posedge core_clk_in);
        clrwdt <= 1'b1;
        @(posedge core_clk_in);
        clrwdt <= 1'b0;
        @(negedge core_clk_in);
        flags(3'b110);
        results();
    end
endmodule : tb
